// file: fsk_checker.sv
// port assertions for the timing and self-test block
`timescale 1ns/1ps
module fsk_checker import fsk_pkg::*; (
  // clock, reset, bus
  input wire logic       core_clk, sys_rst, pready, pslverr,
  // clocks, panel, link
  input wire logic       power_on_clear_n, dmaStrobe_n, clk640, panelData,
  input wire logic [2:0] radio_tx_select, radio_rx_select,
  input wire logic [3:0] displayCode
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  a_tx_onehot: assert property ($onehot0(radio_tx_select))
    else $error("tx select not one-hot");
  a_rx_follows: assert property (radio_tx_select != 0 |-> radio_rx_select == radio_tx_select)
    else $error("rx select differs");
  a_clear_holds: assert property (power_on_clear_n |=> power_on_clear_n)
    else $error("clear dropped");
  a_quiet_clear: assert property (!power_on_clear_n |-> displayCode == DC_NONE)
    else $error("code during clear");
  a_strobe_width: assert property ($fell(dmaStrobe_n) |-> ##74 !dmaStrobe_n ##1 dmaStrobe_n)
    else $error("strobe width");
  a_panel_lit: assert property (panelData |-> displayCode == DC_ALL)
    else $error("panel data outside check");
  a_bit_clk_slow: assert property ($changed(clk640) |=> $stable(clk640) [*8])
    else $error("bit clock too fast");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
endmodule : fsk_checker
bind fsk_link_timing_and_selftest fsk_checker fsk_checker_i (.*);

// file: fsk_link_timing_and_selftest.sv
// timing, keying, channel select, apb registers and self-test sequencer
//
// The register addresses and the APB slave port were left to the implementer.
`timescale 1ns/1ps
module fsk_link_timing_and_selftest import fsk_pkg::*; #(
  parameter int PON_CYCLES  = PON_CYC,
  parameter int DISP_CYCLES = DISP_CYC,
  parameter int REPLY_CYCLES = REPLY_CYC,
  parameter int STB_PERIOD  = STB_P_CYC,
  parameter int ROM_AW      = 8,
  parameter int RAM_AW      = 6,
  parameter int BLINK_BITS  = 9
) (
  // clock and reset
  input  wire logic              core_clk,
  input  wire logic              sys_rst,
  // apb slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // pins from outside
  input  wire logic              xtalIn,
  input  wire logic [2:0]        radioCarrierIn,
  input  wire logic [2:0]        radioDataIn,
  input  wire logic              tandem_line_in,
  input  wire logic              function_switch,
  input  wire logic              mainPowerIn,
  input  wire logic              tandem_present,
  input  wire logic [7:0]        switchStatus,
  // generated clocks and strobes
  output logic                   clk1m92,
  output logic                   clk320k,
  output logic                   clk640,
  output logic                   dmaStrobe_n,
  output logic                   power_on_clear_n,
  // radio and tandem link
  output logic                   tone_tx_out,
  output logic      [2:0]        radio_tx_select,
  output logic      [2:0]        radio_rx_select,
  output logic                   tandem_tx_select,
  output logic                   tandem_line_out,
  output logic                   carrier_detect_n,
  output logic                   radio_rx_bit,
  output logic                   tandem_rx_bit,
  output logic      [7:0]        statusLinesOut,
  // panel
  output logic                   panelData,
  output logic                   panelClk,
  output logic      [3:0]        displayCode,
  output logic      [1:0]        channel_number_display,
  output logic                   channelDisplayOn,
  // program and data memory test ports
  output logic      [ROM_AW-1:0] romAddr,
  input  wire logic [7:0]        romData,
  output logic      [RAM_AW-1:0] ramAddr,
  output logic      [7:0]        ramWrData,
  output logic                   ramWe,
  input  wire logic [7:0]        ramRdData
);
  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  logic [PIN_N-1:0] pinRaw;
  logic [PIN_N-1:0] pinS1;
  logic [PIN_N-1:0] pinS2;
  logic [PIN_N-1:0] pinS3;
  logic [PIN_N-1:0] pinF_r;
  assign pinRaw = {switchStatus, tandem_present, mainPowerIn, function_switch,
                   tandem_line_in, radioDataIn, radioCarrierIn, xtalIn};
  for (genvar gi = 0; gi < PIN_N; gi++) begin : g_sync
    always_ff @(posedge core_clk) begin
      if (sys_rst) begin
        pinS1[gi]  <= 1'b0;
        pinS2[gi]  <= 1'b0;
        pinS3[gi]  <= 1'b0;
        pinF_r[gi] <= 1'b0;
      end else begin
        pinS1[gi] <= pinRaw[gi];
        pinS2[gi] <= pinS1[gi];
        pinS3[gi] <= pinS2[gi];
        // glitch shorter than a cycle never reaches the filtered level
        if (pinS2[gi] == pinS3[gi]) pinF_r[gi] <= pinS3[gi];
      end
    end
  end
  logic fctnTest;
  assign fctnTest = pinF_r[PIN_FUNCTION_SWITCH];

  // ---------------------------------------------------------------
  // clock dividers
  // ---------------------------------------------------------------
  logic       xtalPrev_r;
  logic       tick;
  logic [1:0] cnt320_r;
  logic [10:0] cnt640_r;
  logic [8:0] cntTone_r;
  logic [8:0] toneHalf;
  logic       rise320_r;
  logic       fall640_r;
  logic       keyBit_r;
  logic       toneSq_r;
  logic       txEff;
  assign tick = pinF_r[PIN_XTAL] & ~xtalPrev_r & clk1m92;
  assign toneHalf = keyBit_r ? 9'(HALF_ONE) : 9'(HALF_ZERO);
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      xtalPrev_r <= 1'b0;
      clk1m92    <= 1'b0;
    end else begin
      xtalPrev_r <= pinF_r[PIN_XTAL];
      if (pinF_r[PIN_XTAL] & ~xtalPrev_r) clk1m92 <= ~clk1m92;
    end
  end
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      cnt320_r  <= 2'h0;
      cnt640_r  <= 11'h000;
      clk320k   <= 1'b0;
      clk640    <= 1'b0;
      rise320_r <= 1'b0;
      fall640_r <= 1'b0;
    end else begin
      rise320_r <= 1'b0;
      fall640_r <= 1'b0;
      if (tick) begin
        if (cnt320_r == 2'(HALF_320K - 1)) begin
          cnt320_r  <= 2'h0;
          clk320k   <= ~clk320k;
          rise320_r <= ~clk320k;
        end else begin
          cnt320_r <= cnt320_r + 2'h1;
        end
        if (cnt640_r == 11'(HALF_640 - 1)) begin
          cnt640_r  <= 11'h000;
          clk640    <= ~clk640;
          fall640_r <= clk640;
        end else begin
          cnt640_r <= cnt640_r + 11'h001;
        end
      end
    end
  end
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      keyBit_r  <= 1'b1;
      cntTone_r <= 9'h000;
      toneSq_r  <= 1'b0;
    end else begin
      if (fall640_r) keyBit_r <= txEff;
      if (tick) begin
        if (cntTone_r >= toneHalf - 9'h001) begin
          cntTone_r <= 9'h000;
          toneSq_r  <= ~toneSq_r;
        end else begin
          cntTone_r <= cntTone_r + 9'h001;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // strobe and power-on clear
  // ---------------------------------------------------------------
  logic [31:0] stbCnt_r;
  logic [31:0] ponCnt_r;
  logic        testStart_r;
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      stbCnt_r    <= 32'h0;
      dmaStrobe_n <= 1'b1;
    end else begin
      stbCnt_r    <= (stbCnt_r == 32'(STB_PERIOD - 1)) ? 32'h0 : stbCnt_r + 32'h1;
      dmaStrobe_n <= ~(stbCnt_r < 32'(STB_W_CYC));
    end
  end
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      ponCnt_r         <= 32'h0;
      power_on_clear_n <= 1'b0;
      testStart_r      <= 1'b0;
    end else begin
      testStart_r <= 1'b0;
      if (!power_on_clear_n) begin
        ponCnt_r <= ponCnt_r + 32'h1;
        if (ponCnt_r == 32'(PON_CYCLES - 1)) begin
          power_on_clear_n <= 1'b1;
          testStart_r      <= 1'b1;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // apb registers
  // ---------------------------------------------------------------
  logic [6:0]  ctrl_r;
  logic        apbWr;
  logic        mapped;
  logic        swDispWr;
  logic        updPend_r;
  logic        testBusy;
  logic [31:0] statWord;
  assign apbWr  = psel & penable & pwrite;
  assign mapped = (paddr == REG_CTRL) | (paddr == REG_STAT) | (paddr == REG_SOUT) |
                  (paddr == REG_CMD) | (paddr == REG_DISP);
  assign pready  = psel & penable;
  assign pslverr = psel & penable & ~mapped;
  assign swDispWr = apbWr & (paddr == REG_DISP);
  assign statWord = {12'h000, displayCode, fctnTest, updPend_r, testBusy, tandem_rx_bit,
                     radio_rx_bit, carrier_detect_n, pinF_r[PIN_TPRES],
                     pinF_r[PIN_MAIN], pinF_r[PIN_SW +: 8]};
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      ctrl_r         <= CTRL_RST;
      statusLinesOut <= 8'h00;
      prdata         <= 32'h0;
    end else begin
      if (apbWr & (paddr == REG_CTRL)) ctrl_r <= pwdata[6:0];
      if (apbWr & (paddr == REG_SOUT)) statusLinesOut <= pwdata[7:0];
      // read word is captured in the setup cycle, so pready can be high at once
      if (psel & ~penable & ~pwrite) begin
        case (paddr)
          REG_CTRL: prdata <= {25'h0, ctrl_r};
          REG_STAT: prdata <= statWord;
          REG_SOUT: prdata <= {24'h0, statusLinesOut};
          REG_CMD:  prdata <= {31'h0, updPend_r};
          REG_DISP: prdata <= {28'h0, displayCode};
          default:  prdata <= 32'h0;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // status update request and reply watch
  // ---------------------------------------------------------------
  logic        updTandem_r;
  logic [31:0] updTmr_r;
  logic        faultF7_r;
  logic        faultFr_r;
  logic        faultEr_r;
  logic        cmdWr;
  assign cmdWr = apbWr & (paddr == REG_CMD);
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      updPend_r   <= 1'b0;
      updTandem_r <= 1'b0;
      updTmr_r    <= 32'h0;
      faultF7_r   <= 1'b0;
      faultFr_r   <= 1'b0;
      faultEr_r   <= 1'b0;
    end else begin
      faultF7_r <= 1'b0;
      faultFr_r <= 1'b0;
      faultEr_r <= 1'b0;
      if (cmdWr & pwdata[CMD_UPD]) begin
        if (ctrl_r[CTRL_CH +: 2] == 2'h3 && !ctrl_r[CTRL_R3ATT]) begin
          faultEr_r <= 1'b1;
        end else begin
          updPend_r   <= 1'b1;
          updTandem_r <= ctrl_r[CTRL_TANDEM];
          updTmr_r    <= 32'h0;
        end
      end else if (updPend_r) begin
        updTmr_r <= updTmr_r + 32'h1;
        if (cmdWr & (updTandem_r ? pwdata[CMD_TECHO] : pwdata[CMD_RECHO])) begin
          updPend_r <= 1'b0;
        end else if (updTmr_r == 32'(REPLY_CYCLES - 1)) begin
          updPend_r <= 1'b0;
          faultFr_r <= updTandem_r;
          faultF7_r <= ~updTandem_r;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // self-test sequencer
  // ---------------------------------------------------------------
  fsk_state_t        state_r;
  logic [31:0]       tmr_r;
  logic [6:0]        bitCnt_r;
  logic [2:0]        sub_r;
  logic [ROM_AW-1:0] rAddr_r;
  logic [15:0]       sum_r;
  logic [7:0]        hiByte_r;
  logic [7:0]        orig_r;
  logic              repeat_r;
  logic [1:0]        tstCh_r;
  logic              tstCarr_r;
  logic              tstBit_r;
  logic [1:0]        lbCnt_r;
  logic [3:0]        failCode_r;
  logic              romLast;
  logic              chkOk;
  assign testBusy = (state_r != ST_IDLE);
  assign romLast  = (rAddr_r == {ROM_AW{1'b1}});
  assign chkOk    = ~carrier_detect_n & (radio_rx_bit == ~tstBit_r);
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      state_r     <= ST_IDLE;
      tmr_r       <= 32'h0;
      bitCnt_r    <= 7'h00;
      sub_r       <= 3'h0;
      rAddr_r     <= '0;
      sum_r       <= 16'h0000;
      hiByte_r    <= 8'h00;
      orig_r      <= 8'h00;
      repeat_r    <= 1'b0;
      tstCh_r     <= 2'h3;
      tstCarr_r   <= 1'b0;
      tstBit_r    <= 1'b1;
      lbCnt_r     <= 2'h0;
      failCode_r  <= DC_F1;
      panelData   <= 1'b0;
      romAddr     <= '0;
      ramAddr     <= '0;
      ramWrData   <= 8'h00;
      ramWe       <= 1'b0;
      displayCode <= DC_NONE;
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (faultEr_r) displayCode <= DC_ER;
          else if (faultF7_r) displayCode <= DC_F7;
          else if (faultFr_r) displayCode <= DC_FR;
          else if (swDispWr) displayCode <= pwdata[3:0];
          if (testStart_r | (fctnTest & power_on_clear_n)) begin
            state_r     <= ST_DSHIFT;
            repeat_r    <= ~testStart_r;
            bitCnt_r    <= 7'h00;
            displayCode <= DC_ALL;
          end
        end
        ST_DSHIFT: begin
          panelData <= 1'b1;
          if (rise320_r) begin
            bitCnt_r <= bitCnt_r + 7'h01;
            if (bitCnt_r == 7'(DISP_BITS * DISP_PASSES - 1)) begin
              state_r <= ST_DHOLD;
              tmr_r   <= 32'h0;
            end
          end
        end
        ST_DHOLD: begin
          panelData <= 1'b0;
          tmr_r <= tmr_r + 32'h1;
          if (tmr_r == 32'(DISP_CYCLES - 1)) begin
            state_r <= ST_ROM;
            rAddr_r <= '0;
            sub_r   <= 3'h0;
            sum_r   <= 16'h0000;
          end
        end
        ST_ROM: begin
          sub_r <= sub_r + 3'h1;
          if (sub_r == 3'h0) romAddr <= rAddr_r;
          if (sub_r == 3'h2) begin
            sub_r   <= 3'h0;
            rAddr_r <= rAddr_r + 1'b1;
            if (romLast) begin
              if ({hiByte_r, romData} == sum_r) begin
                state_r <= ST_RAM;
                rAddr_r <= '0;
              end else begin
                failCode_r <= DC_F1;
                state_r    <= ST_FAIL;
              end
            end else if (rAddr_r == {{(ROM_AW-1){1'b1}}, 1'b0}) begin
              hiByte_r <= romData;
            end else begin
              sum_r <= sum_r + {8'h00, romData};
            end
          end
        end
        ST_RAM: begin
          sub_r <= sub_r + 3'h1;
          case (sub_r)
            3'h0: ramAddr <= rAddr_r[RAM_AW-1:0];
            3'h2: begin
              orig_r    <= ramRdData;
              ramWe     <= 1'b1;
              ramWrData <= RAM_PATTERN;
            end
            3'h5: begin
              ramWe     <= 1'b1;
              // repeat runs keep the contents, power-up runs leave zero
              ramWrData <= repeat_r ? orig_r : 8'h00;
              if (ramRdData != RAM_PATTERN) begin
                failCode_r <= DC_F1;
                state_r    <= ST_FAIL;
              end
            end
            3'h6: begin
              sub_r   <= 3'h0;
              rAddr_r <= rAddr_r + 1'b1;
              if (rAddr_r[RAM_AW-1:0] == {RAM_AW{1'b1}}) begin
                state_r <= ST_LIDLE;
                tstCh_r <= 2'h3;
              end
            end
            default: ramWe <= 1'b0;
          endcase
        end
        ST_LIDLE: begin
          ramWe    <= 1'b0;
          tstBit_r <= 1'b1;
          if (carrier_detect_n & fall640_r) begin
            tstCarr_r <= 1'b1;
            lbCnt_r   <= 2'h0;
            state_r   <= ST_LDLY1;
          end
        end
        ST_LDLY1, ST_LDLY2: begin
          if (fall640_r) begin
            lbCnt_r <= lbCnt_r + 2'h1;
            if (lbCnt_r == 2'(LB_PERIODS - 1)) begin
              if (!chkOk) begin
                failCode_r <= DC_F2;
                state_r    <= ST_FAIL;
              end else if (state_r == ST_LDLY1) begin
                tstBit_r <= 1'b0;
                state_r  <= ST_LEDGE2;
              end else begin
                tstCarr_r <= 1'b0;
                tstCh_r   <= tstCh_r - 2'h1;
                state_r   <= (tstCh_r == 2'h1) ? ST_DONE : ST_LIDLE;
                if (tstCh_r == 2'h1) displayCode <= DC_GD;
              end
            end
          end
        end
        ST_LEDGE2: begin
          if (fall640_r) begin
            lbCnt_r <= 2'h0;
            state_r <= ST_LDLY2;
          end
        end
        ST_FAIL: begin
          ramWe       <= 1'b0;
          tstCarr_r   <= 1'b0;
          displayCode <= failCode_r;
          state_r     <= ST_DONE;
        end
        ST_DONE: begin
          tstBit_r <= 1'b1;
          state_r  <= ST_IDLE;
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // channel routing and panel outputs
  // ---------------------------------------------------------------
  logic [1:0] selCh;
  logic       carrOn;
  logic [2:0] carrVec;
  logic [2:0] dataVec;
  logic [1:0] selIdx;
  logic [BLINK_BITS-1:0] blink_r;
  assign selCh   = testBusy ? tstCh_r : ctrl_r[CTRL_CH +: 2];
  assign carrOn  = testBusy ? tstCarr_r : ctrl_r[CTRL_CARR];
  assign txEff   = testBusy ? tstBit_r : ctrl_r[CTRL_TXBIT];
  assign carrVec = pinF_r[PIN_CARR +: 3];
  assign dataVec = pinF_r[PIN_DATA +: 3];
  assign selIdx  = selCh - 2'h1;
  assign panelClk = clk320k;
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      tone_tx_out      <= 1'b0;
      radio_tx_select  <= 3'h0;
      radio_rx_select  <= 3'h0;
      tandem_tx_select <= 1'b0;
      tandem_line_out  <= 1'b0;
      carrier_detect_n <= 1'b1;
      radio_rx_bit     <= 1'b0;
      tandem_rx_bit    <= 1'b0;
      blink_r          <= '0;
      channel_number_display <= 2'h0;
      channelDisplayOn <= 1'b1;
    end else begin
      tone_tx_out <= carrOn & toneSq_r;
      for (int i = 0; i < 3; i++) begin
        radio_tx_select[i] <= carrOn & (selCh == 2'(i + 1));
        radio_rx_select[i] <= (selCh == 2'(i + 1));
      end
      carrier_detect_n <= ~((selCh != 2'h0) & carrVec[selIdx]);
      radio_rx_bit     <= (selCh != 2'h0) & dataVec[selIdx];
      tandem_tx_select <= ~testBusy & ctrl_r[CTRL_TANDEM];
      tandem_line_out  <= ~testBusy & ctrl_r[CTRL_TANDEM] & keyBit_r;
      tandem_rx_bit    <= pinF_r[PIN_TIN];
      if (fall640_r) blink_r <= blink_r + 1'b1;
      channel_number_display <= ctrl_r[CTRL_CH +: 2];
      channelDisplayOn <= ~ctrl_r[CTRL_PROB] | blink_r[BLINK_BITS-1];
    end
  end
endmodule : fsk_link_timing_and_selftest

// file: fsk_pkg.sv
// shared constants, register map and state type for the fsk timing and self-test block
package fsk_pkg;
  // ---------------------------------------------------------------
  // clocking
  // ---------------------------------------------------------------
  localparam int CLK_HZ      = 50_000_000;
  localparam int TICK_HZ     = 1_920_000;
  localparam int F_DISP_CLK  = 320_000;
  localparam int F_BIT       = 640;
  localparam int F_ONE       = 2560;
  localparam int F_ZERO      = 3200;
  localparam int HALF_320K   = TICK_HZ / (2 * F_DISP_CLK);
  localparam int HALF_640    = TICK_HZ / (2 * F_BIT);
  localparam int HALF_ONE    = TICK_HZ / (2 * F_ONE);
  localparam int HALF_ZERO   = TICK_HZ / (2 * F_ZERO);
  // ---------------------------------------------------------------
  // times and derived cycle counts
  // ---------------------------------------------------------------
  localparam int PON_MS      = 1000;
  localparam int DISP_MS     = 3000;
  localparam int REPLY_MS    = 100;
  localparam int STB_W_NS    = 1500;
  localparam int STB_P_US    = 1560;
  localparam int PON_CYC     = PON_MS * (CLK_HZ / 1000);
  localparam int DISP_CYC    = DISP_MS * (CLK_HZ / 1000);
  localparam int REPLY_CYC   = REPLY_MS * (CLK_HZ / 1000);
  localparam int STB_W_CYC   = (STB_W_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int STB_P_CYC   = STB_P_US * (CLK_HZ / 1_000_000);
  localparam int LB_PERIODS  = 2;
  localparam int DISP_PASSES = 2;
  localparam int DISP_BITS   = 32;
  localparam logic [7:0] RAM_PATTERN = 8'haa;
  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STAT = 8'h04;
  localparam logic [7:0] REG_SOUT = 8'h08;
  localparam logic [7:0] REG_CMD  = 8'h0c;
  localparam logic [7:0] REG_DISP = 8'h10;
  localparam int CTRL_CH     = 0;
  localparam int CTRL_TANDEM = 2;
  localparam int CTRL_TXBIT  = 3;
  localparam int CTRL_CARR   = 4;
  localparam int CTRL_PROB   = 5;
  localparam int CTRL_R3ATT  = 6;
  localparam logic [6:0] CTRL_RST = 7'h00;
  localparam int CMD_UPD     = 0;
  localparam int CMD_RECHO   = 1;
  localparam int CMD_TECHO   = 2;
  // ---------------------------------------------------------------
  // panel codes
  // ---------------------------------------------------------------
  localparam logic [3:0] DC_NONE = 4'h0;
  localparam logic [3:0] DC_ALL  = 4'h1;
  localparam logic [3:0] DC_GD   = 4'h2;
  localparam logic [3:0] DC_F1   = 4'h3;
  localparam logic [3:0] DC_F2   = 4'h4;
  localparam logic [3:0] DC_F7   = 4'h5;
  localparam logic [3:0] DC_FR   = 4'h6;
  localparam logic [3:0] DC_ER   = 4'h7;
  // ---------------------------------------------------------------
  // synchronised pin bus positions
  // ---------------------------------------------------------------
  localparam int PIN_XTAL  = 0;
  localparam int PIN_CARR  = 1;
  localparam int PIN_DATA  = 4;
  localparam int PIN_TIN   = 7;
  localparam int PIN_FUNCTION_SWITCH  = 8;
  localparam int PIN_MAIN  = 9;
  localparam int PIN_TPRES = 10;
  localparam int PIN_SW    = 11;
  localparam int PIN_N     = 19;

  typedef enum logic [10:0] {
    ST_IDLE   = 11'h001,
    ST_DSHIFT = 11'h002,
    ST_DHOLD  = 11'h004,
    ST_ROM    = 11'h008,
    ST_RAM    = 11'h010,
    ST_LIDLE  = 11'h020,
    ST_LDLY1  = 11'h040,
    ST_LEDGE2 = 11'h080,
    ST_LDLY2  = 11'h100,
    ST_FAIL   = 11'h200,
    ST_DONE   = 11'h400
  } fsk_state_t;
endpackage : fsk_pkg

// file: fsk_radio_model.sv
// loopback radio model for the tone link
`timescale 1ns/1ps
module fsk_radio_model #(parameter logic [2:0] LOADED = 3'b011) (
  // from block
  input  wire logic       core_clk,
  input  wire logic       tone_tx_out,
  input  wire logic [2:0] radio_tx_select,
  // to block
  output logic      [2:0] radioCarrierIn = 3'b000,
  output logic      [2:0] radioDataIn    = 3'b000
);
  int   half  = 0;
  logic last  = 0;
  logic rxBit = 0;
  always @(posedge core_clk) begin
    last <= tone_tx_out;
    half <= tone_tx_out != last ? 0 : half + 1;
    // short half period (higher tone) comes back as a one
    if (tone_tx_out != last) rxBit <= half < 2700;
    radioCarrierIn <= LOADED & radio_tx_select;
    // released lines toggle so a stale bit never reads as valid
    radioDataIn <= LOADED & radio_tx_select & {3{rxBit}} | ~(LOADED & radio_tx_select) & ~radioDataIn;
  end
endmodule : fsk_radio_model

// file: tb_top.sv
// bench: power-up self-test, register rows, update faults
`timescale 1ns/1ps
module tb_top import fsk_pkg::*;;
  logic core_clk = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0, xtalIn = 0, err;
  logic function_switch = 0, mainPowerIn = 1, tandem_present = 0, tandem_line_in = 0, xtalPh = 0;
  logic pready, pslverr, clk1m92, clk320k, clk640, dmaStrobe_n, power_on_clear_n, tone_tx_out;
  logic tandem_tx_select, tandem_line_out, carrier_detect_n, radio_rx_bit, tandem_rx_bit;
  logic panelData, panelClk, channelDisplayOn, ramWe;
  logic [1:0] ramAddr, channel_number_display;
  logic [2:0] romAddr, radio_tx_select, radio_rx_select, radioCarrierIn, radioDataIn, firstTx = 0;
  logic [3:0] displayCode;
  logic [7:0] paddr = 0, romData = 0, ramRdData = 0, switchStatus = 8'h5a, statusLinesOut, ramWrData;
  logic [7:0] ram [4] = '{default: 8'h00};
  logic [31:0] pwdata = 0, prdata, rd;
  int fails = 0, checked = 0, n;
  // rows: control word, rx select, tx select, tandem select
  localparam logic [13:0] ROWS [4] = '{14'h0892, 14'h0924, 14'h01c0, 14'h0201};
  fsk_link_timing_and_selftest #(.PON_CYCLES(200), .DISP_CYCLES(100), .REPLY_CYCLES(100),
    .STB_PERIOD(300), .ROM_AW(3), .RAM_AW(2)) fsk_link_timing_and_selftest_i (.*);
  fsk_radio_model fsk_radio_model_i (.*);
  always #10 core_clk = ~core_clk;
  // rom sums bytes 0..5 to 16'h0015, held in the last two bytes
  always @(posedge core_clk) begin
    // crystal stand-in: two-cycle halves still pass the pin agree filter
    xtalPh <= ~xtalPh;
    if (xtalPh) xtalIn <= ~xtalIn;
    if (ramWe) ram[ramAddr] <= ramWrData;
    ramRdData <= ram[ramAddr];
    romData <= romAddr < 6 ? 8'(romAddr) + 8'h01 : romAddr == 7 ? 8'h15 : 8'h00;
    if (!sys_rst && firstTx === 3'b000) firstTx <= radio_tx_select;
  end
  task chk(input logic ok, input string m);
    checked++;
    if (ok !== 1'b1) begin
      fails++;
      $display("CHECK FAILED at %0t: %s", $time, m);
    end
  endtask : chk
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk) penable <= 1;
    do @(posedge core_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge core_clk);
  endtask : apb
  task waitCode(input logic [3:0] c, input int lim);
    n = 0;
    while (displayCode !== c && n < lim) begin
      @(posedge core_clk);
      n++;
    end
    chk(displayCode === c, "panel code");
  endtask : waitCode
  task results;
    $display("fails=%0d checked=%0d", fails, checked);
    if (fails == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : results
  initial begin
    repeat (8) @(posedge core_clk);
    sys_rst <= 0;
    tandem_line_in <= 1;
    n = 0;
    while (power_on_clear_n !== 1'b1 && n < 1000) begin
      @(posedge core_clk);
      n++;
    end
    chk(n >= 198 && n <= 202, "clear width");
    // radio 3 is not loaded, so the loopback must stop on it
    waitCode(DC_F2, 80000);
    chk(firstTx === 3'b100, "first channel");
    for (int i = 0; i < 4; i++) begin
      apb(1, REG_CTRL, 32'(ROWS[i][13:7]));
      @(posedge core_clk);
      chk({radio_rx_select, radio_tx_select, tandem_tx_select} === ROWS[i][6:0], "selects");
    end
    apb(1, REG_SOUT, 32'h0000_00c3);
    chk(statusLinesOut === 8'hc3, "status lines");
    apb(0, REG_STAT, 32'h0);
    chk(rd[19:0] === 20'h4155a, "status read");
    apb(0, 8'h40, 32'h0);
    chk(err === 1'b1 && rd === 32'h0, "unmapped");
    apb(1, REG_CTRL, 32'h03);
    apb(1, REG_CMD, 32'h01);
    waitCode(DC_ER, 10);
    apb(1, REG_CTRL, 32'h01);
    apb(1, REG_CMD, 32'h01);
    waitCode(DC_F7, 200);
    apb(1, REG_CTRL, 32'h25);
    @(posedge core_clk);
    chk(channelDisplayOn === 1'b0 && channel_number_display === 2'h1, "problem display");
    results();
  end
  initial begin
    repeat (90000) @(posedge core_clk);
    fails++;
    results();
  end
endmodule : tb_top
